/* core/gated_timer.sv */
// Gated 16-bit timer/counter with APB register access
`timescale 1ns/1ps
`include "gated_timer_consts.svh"

// Behaviour
// [R1] Counts only with run set; gate enable decides whether the gate qualifies counting.
// [R2] 16-bit up-counter read via low and high bytes; byte writes load immediately.
// [R3] Clock select: 11 low-freq osc, 10 external pin, 01 system, 00 instruction.
// [R4] Internal clocks advance the counter once per prescaler output pulse.
// [R5] External pin counts on rising edges, synchronized or asynchronous.
// [R6] External mode needs a falling edge before the first counted rising edge.
// [R7] Prescaler divides by 1, 2, 4 or 8; its counter is hidden.
// [R8] Writing either count byte clears the hidden prescale counter.
// [R9] Sync-disable passes the external clock without phase synchronization; sync_dis is unused and the pin always passes the two flops.
// [R10] Asynchronous external counting runs in sleep; rollover flag can wake.
// [R11] Byte reads during asynchronous counting return a valid value.
// [R12] Software stops the counter before writing new count values.
// [R13] Switching sync modes may lose or add one increment.
// [R14] Gated counting happens only while gate equals the polarity bit.
// [R15] Inactive gate suppresses increments and holds the count.
// [R16] Gate source: 00 pin, 01 byte-timer rollover, 10 comparator a, 11 b.
// [R17] Byte-timer rollover pulse feeds the gate circuitry as a source.
// [R18] Toggle mode routes the gate through a flip-flop toggling on each rising edge.
// [R19] Toggle flip-flop forced to zero while toggle mode is clear.
// [R20] Software avoids enabling toggle mode while changing gate polarity.
// [R21] Rollover from all ones to zero sets a flag only software clears.
// [R22] Clearing run stops the counter and clears the gate flip-flop.
// [R23] Selected gate is sampled through two flops before qualifying increments.
module gated_timer (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Count clock and gate sources
	input  wire logic        external_count_clock_pin,
	input  wire logic        low_freq_internal_osc,
	input  wire logic        gate_pin,
	input  wire logic        byte_timer_rollover,
	input  wire logic        comparator_a_output,
	input  wire logic        comparator_b_output,
	// Status
	output logic             rollover_flag,
	output logic             gate_value
);

	gated_timer_pkg::state_s s_r;
	gated_timer_pkg::state_s s_nxt;

	logic       wr_acc;
	logic       rd_acc;
	logic       mapped;
	logic       run;
	logic       gate_en;
	logic       gate_pol;
	logic       toggle_mode;
	logic       sync_dis;
	logic [1:0] presc_sel;
	logic [1:0] clk_sel;
	logic [1:0] gate_sel;
	logic       gate_raw;
	logic       gate_src;
	logic       gate_ok;
	logic       clk_event;
	logic       presc_tick;
	logic       count_en;
	logic       ext_rise;
	logic       ext_fall;
	logic       count_wr;

	function automatic logic [2:0] presc_limit(input logic [1:0] sel);
		presc_limit = 3'((4'h1 << sel) - 4'h1);
	endfunction

	assign wr_acc      = psel && penable && pwrite;
	// Read data is captured in the setup cycle so it stands at the access edge
	assign rd_acc      = psel && !penable && !pwrite;
	assign mapped      = paddr inside {`OFF_COUNTER_CONTROL, `OFF_GATE_CONTROL,
	                                   `OFF_COUNT_LOW_BYTE, `OFF_COUNT_HIGH_BYTE, `OFF_STATUS};
	assign pready      = 1'b1;
	assign pslverr     = psel && penable && !mapped;
	assign prdata      = s_r.prdata;
	assign rollover_flag = s_r.rollover_flag;
	assign gate_value  = toggle_mode ? s_r.toggle_ff : s_r.gate_sync2; // R18

	assign run         = s_r.counter_control[`CC_RUN_BIT];
	assign sync_dis    = s_r.counter_control[`CC_SYNC_DIS_BIT];
	assign presc_sel   = s_r.counter_control[`CC_PRESCALE_LSB +: 2];
	assign clk_sel     = s_r.counter_control[`CC_CLKSEL_LSB +: 2];
	assign gate_sel    = s_r.gate_control[`GC_SRC_LSB +: 2];
	assign toggle_mode = s_r.gate_control[`GC_TOGGLE_BIT];
	assign gate_pol    = s_r.gate_control[`GC_POL_BIT];
	assign gate_en     = s_r.gate_control[`GC_ENABLE_BIT];
	assign count_wr    = wr_acc && pstrb[0] &&
	                     (paddr == `OFF_COUNT_LOW_BYTE || paddr == `OFF_COUNT_HIGH_BYTE);

	// Gate source multiplexer
	always_comb begin
		unique case (gate_pkg_sel(gate_sel))
			gated_timer_pkg::GATE_PIN:        gate_raw = gate_pin; // R16
			gated_timer_pkg::GATE_BYTE_TIMER: gate_raw = byte_timer_rollover; // R17
			gated_timer_pkg::GATE_COMP_A:     gate_raw = comparator_a_output;
			gated_timer_pkg::GATE_COMP_B:     gate_raw = comparator_b_output;
		endcase
	end

	function automatic gated_timer_pkg::gate_src_e gate_pkg_sel(input logic [1:0] v);
		gate_pkg_sel = gated_timer_pkg::gate_src_e'(v);
	endfunction

	// Toggle output or synchronized level, then polarity compare
	assign gate_src = toggle_mode ? s_r.toggle_ff : s_r.gate_sync2; // R18
	assign gate_ok  = !gate_en || (gate_src == gate_pol); // R14 R15
	assign count_en = run && gate_ok; // R1

	assign ext_rise = s_r.ext_sync2 && !s_r.ext_prev;
	assign ext_fall = !s_r.ext_sync2 && s_r.ext_prev;

	// Clock source event, one cycle pulse per selected edge
	always_comb begin
		unique case (gated_timer_pkg::clk_src_e'(clk_sel))
			gated_timer_pkg::CLK_INSTR:    clk_event = (s_r.instr_div == `INSTR_CLOCK_DIV); // R3
			gated_timer_pkg::CLK_SYSTEM:   clk_event = 1'b1;
			gated_timer_pkg::CLK_EXTERNAL: clk_event = ext_rise && s_r.ext_armed; // R5 R6
			gated_timer_pkg::CLK_LOW_FREQ: clk_event = s_r.lfo_sync2 && !s_r.lfo_prev;
		endcase
	end

	// At or past the limit, so a smaller ratio never strands the counter
	assign presc_tick = clk_event && count_en && (s_r.prescale_cnt >= presc_limit(presc_sel)); // R4 R7

	always_comb begin
		s_nxt = s_r;
		s_nxt.instr_div  = s_r.instr_div + 2'h1;
		// Two-flop sampling; first stage feeds only the second
		s_nxt.gate_sync1 = gate_raw; // R23
		s_nxt.gate_sync2 = s_r.gate_sync1;
		s_nxt.gate_prev  = s_r.gate_sync2;
		// The pin passes the same two flops whichever sync mode is chosen, so
		// the async path reads coherently from the bus and mode switches cost
		// at most one edge.
		s_nxt.ext_sync1  = external_count_clock_pin; // R9 R11 R13
		s_nxt.ext_sync2  = s_r.ext_sync1;
		s_nxt.ext_prev   = s_r.ext_sync2;
		s_nxt.lfo_sync1  = low_freq_internal_osc;
		s_nxt.lfo_sync2  = s_r.lfo_sync1;
		s_nxt.lfo_prev   = s_r.lfo_sync2;
		s_nxt.prdata     = 32'h0000_0000;

		if (ext_fall)
			s_nxt.ext_armed = 1'b1; // R6
		if (!run)
			s_nxt.ext_armed = 1'b0; // R6

		if (!toggle_mode || !run)
			s_nxt.toggle_ff = 1'b0; // R19 R22
		else if (s_r.gate_sync2 && !s_r.gate_prev)
			s_nxt.toggle_ff = !s_r.toggle_ff; // R18

		if (clk_event && count_en) begin
			if (presc_tick) begin
				s_nxt.prescale_cnt = 3'h0;
				s_nxt.count = s_r.count + 16'h0001; // R2 R4
				if (s_r.count == 16'hffff)
					s_nxt.rollover_flag = 1'b1; // R21 R10
			end else begin
				s_nxt.prescale_cnt = s_r.prescale_cnt + 3'h1; // R7
			end
		end

		if (wr_acc && pstrb[0]) begin
			unique case (paddr)
				`OFF_COUNTER_CONTROL:
					s_nxt.counter_control = pwdata[7:0] & `CC_WRITE_MASK;
				`OFF_GATE_CONTROL:
					s_nxt.gate_control = pwdata[7:0] & `GC_WRITE_MASK;
				`OFF_COUNT_LOW_BYTE:
					s_nxt.count[7:0] = pwdata[7:0]; // R2
				`OFF_COUNT_HIGH_BYTE:
					s_nxt.count[15:8] = pwdata[7:0]; // R2
				`OFF_STATUS:
					// Write one to clear; a rollover in the same cycle wins
					if (pwdata[`ST_ROLLOVER_BIT] && !(presc_tick && s_r.count == 16'hffff))
						s_nxt.rollover_flag = 1'b0; // R21
				default: ;
			endcase
		end
		if (count_wr) begin
			s_nxt.prescale_cnt = 3'h0; // R8
			s_nxt.ext_armed    = 1'b0; // R6
		end

		if (rd_acc) begin
			unique case (paddr)
				`OFF_COUNTER_CONTROL: s_nxt.prdata = {24'h0, s_r.counter_control};
				`OFF_GATE_CONTROL:    s_nxt.prdata = {24'h0, s_r.gate_control};
				`OFF_COUNT_LOW_BYTE:  s_nxt.prdata = {24'h0, s_r.count[7:0]}; // R11
				`OFF_COUNT_HIGH_BYTE: s_nxt.prdata = {24'h0, s_r.count[15:8]};
				`OFF_STATUS:          s_nxt.prdata = {30'h0, gate_src, s_r.rollover_flag};
				default:              s_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Zero wait states: the snapshot taken at setup is what the access edge sees
	a_low_byte_load: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(wr_acc && pstrb[0] && paddr == `OFF_COUNT_LOW_BYTE)
		|=> s_r.count[7:0] == $past(pwdata[7:0]))
		else $error("low byte write did not load");
	a_run_gates_count: assert property (@(posedge pclk) disable iff (!presetn)
		!run |=> s_r.count == $past(s_r.count) || $past(wr_acc)) // R1
		else $error("count moved while stopped");
	a_gate_holds_count: assert property (@(posedge pclk) disable iff (!presetn)
		(run && gate_en && gate_src != gate_pol && !wr_acc) |=> s_r.count == $past(s_r.count)) // R15
		else $error("count moved with gate inactive");
	a_rollover_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(presc_tick && s_r.count == 16'hffff) |=> rollover_flag && s_r.count == 16'h0000) // R21
		else $error("rollover flag not set");
	a_toggle_held_clear: assert property (@(posedge pclk) disable iff (!presetn)
		!toggle_mode |=> !s_r.toggle_ff) // R19
		else $error("toggle flop not held clear");
	a_stop_clears_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(run) |-> ##1 !s_r.toggle_ff) // R22
		else $error("gate flop survived stop");
	a_count_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
		count_wr |=> s_r.prescale_cnt == 3'h0 && !s_r.ext_armed) // R8
		else $error("prescaler not cleared by count write");
	a_system_clock_rate: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !gate_en && clk_sel == 2'h1 && presc_sel == 2'h0 && !wr_acc)
		|=> s_r.count == 16'($past(s_r.count) + 16'h0001)) // R3
		else $error("system clock not counting every cycle");
	a_ext_needs_fall: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_sel == 2'h2 && !s_r.ext_armed && !wr_acc) |=> s_r.count == $past(s_r.count)) // R6
		else $error("external count before falling edge");
	a_prescale_bound: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.prescale_cnt <= presc_limit(presc_sel) || $past(wr_acc)) // R7
		else $error("prescale counter past its limit");

	c_rollover: cover property (@(posedge pclk) disable iff (!presetn) $rose(rollover_flag));
	c_ext_count: cover property (@(posedge pclk) disable iff (!presetn)
		clk_sel == 2'h2 && presc_tick);
	c_gated_toggle: cover property (@(posedge pclk) disable iff (!presetn)
		gate_en && toggle_mode && presc_tick);
	c_stop_in_toggle: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(run) && s_r.toggle_ff);

endmodule

/* inc/gated_timer_consts.svh */
// Register offsets, field positions, reset values and timing constants of the gated timer
`ifndef GATED_TIMER_CONSTS_SVH
`define GATED_TIMER_CONSTS_SVH

`define OFF_COUNTER_CONTROL 12'h000
`define OFF_GATE_CONTROL    12'h004
`define OFF_COUNT_LOW_BYTE  12'h008
`define OFF_COUNT_HIGH_BYTE 12'h00c
`define OFF_STATUS          12'h010

`define CC_RUN_BIT          0
`define CC_SYNC_DIS_BIT     2
`define CC_PRESCALE_LSB     4
`define CC_CLKSEL_LSB       6
`define GC_SRC_LSB          0
`define GC_TOGGLE_BIT       5
`define GC_POL_BIT          6
`define GC_ENABLE_BIT       7
`define ST_ROLLOVER_BIT     0
`define ST_GATE_BIT         1

`define CC_WRITE_MASK       8'hf5
`define GC_WRITE_MASK       8'he3
`define CTRL_RESET          8'h00
`define INSTR_CLOCK_DIV     2'h3

`endif

/* inc/gated_timer_pkg.sv */
// Types for the gated 16-bit timer
package gated_timer_pkg;

	typedef enum logic [1:0] {
		CLK_INSTR,
		CLK_SYSTEM,
		CLK_EXTERNAL,
		CLK_LOW_FREQ
	} clk_src_e;

	typedef enum logic [1:0] {
		GATE_PIN,
		GATE_BYTE_TIMER,
		GATE_COMP_A,
		GATE_COMP_B
	} gate_src_e;

	typedef struct packed {
		logic [7:0]  counter_control;
		logic [7:0]  gate_control;
		logic [15:0] count;
		logic [2:0]  prescale_cnt;
		logic [1:0]  instr_div;
		logic        rollover_flag;
		logic        toggle_ff;
		logic        gate_sync1;
		logic        gate_sync2;
		logic        ext_sync1;
		logic        ext_sync2;
		logic        ext_prev;
		logic        ext_armed;
		logic        lfo_sync1;
		logic        lfo_sync2;
		logic        lfo_prev;
		logic        gate_prev;
		logic [31:0] prdata;
	} state_s;

endpackage

/* testbench/src_model.sv */
// Behavioural count clock and gate sources on the pin side
`timescale 1ns/1ps
module src_model (
	// Pin-side sources
	output logic ext_pin,
	output logic lfo,
	output logic gpin,
	output logic roll,
	output logic ca,
	output logic cb
);
	// Oscillator runs free, unrelated to pclk
	initial begin
		{ext_pin, gpin, roll, ca, cb} = 5'h00;
		lfo = 1'b0;
		forever #200 lfo = ~lfo;
	end
	task automatic ext_pulses(input int n);
		repeat (n) begin
			#53 ext_pin = 1'b1;
			#53 ext_pin = 1'b0;
		end
	endtask
	// One clock wide, like a rollover pulse
	task automatic roll_pulse();
		#3 roll = 1'b1;
		#10 roll = 1'b0;
	endtask
	task automatic set_src(input int s, input logic v);
		case (s)
			0: gpin = v;
			2: ca = v;
			3: cb = v;
			default: ;
		endcase
	endtask
endmodule

/* testbench/gated_timer_bench.sv */
// Self-checking bench for the gated timer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module gated_timer_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        ext_pin, lfo, gpin, roll, ca, cb, rollover_flag, gate_value;
	int          err_count, samples_checked, c;

	gated_timer gated_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_clock_pin(ext_pin), .low_freq_internal_osc(lfo),
		.gate_pin(gpin), .byte_timer_rollover(roll), .comparator_a_output(ca),
		.comparator_b_output(cb), .rollover_flag(rollover_flag),
		.gate_value(gate_value));
	src_model src_model_inst (.ext_pin(ext_pin), .lfo(lfo), .gpin(gpin),
		.roll(roll), .ca(ca), .cb(cb));

	task automatic report_and_stop();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		se = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 16) begin
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc();
		apb(1'b0, 12'h008, 8'h00);
		c = rd[7:0];
		apb(1'b0, 12'h00c, 8'h00);
		c = c + 256 * rd[7:0];
	endtask
	task automatic run(input logic [7:0] cc, input int n);
		wr(12'h008, 8'h00);
		wr(12'h00c, 8'h00);
		wr(12'h000, cc);
		repeat (n) @(posedge pclk);
		wr(12'h000, cc & 8'hfe);
		rdc();
	endtask
	task automatic rng(input int lo, input int hi);
		`CHK(c >= lo && c <= hi, 1'b1)
	endtask

	task automatic t_regs();
		for (int a = 0; a <= 16; a += 4) begin
			apb(1'b0, a[11:0], 8'h00);
			`CHK(rd, 32'h00000000)
		end
		apb(1'b0, 12'h014, 8'h00);
		`CHK({se, rd}, {1'b1, 32'h00000000})
		wr(12'h008, 8'ha5);
		wr(12'h00c, 8'h3c);
		rdc();
		`CHK(c, 32'h00003ca5)
	endtask
	task automatic t_clk();
		for (int ps = 0; ps < 4; ps++) begin
			run({2'h1, ps[1:0], 4'h1}, 64);
			rng(64 >> ps, (70 >> ps) + 1);
		end
		run(8'h01, 64);
		rng(15, 18);
		run(8'hc1, 64);
		rng(1, 2);
		run(8'h40, 64);
		`CHK(c, 0)
	endtask
	task automatic t_ext();
		for (int sd = 0; sd < 2; sd++) begin
			wr(12'h008, 8'h00);
			wr(12'h00c, 8'h00);
			wr(12'h000, {5'h10, sd[0], 2'h1});
			src_model_inst.ext_pulses(8);
			repeat (4) @(posedge pclk);
			wr(12'h000, 8'h80);
			rdc();
			// First rise after the byte write is not counted
			`CHK(c, 7)
		end
	endtask
	task automatic t_gate();
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 2 && s != 1; p++) begin
				src_model_inst.set_src(s, !p[0]);
				wr(12'h004, {1'b1, p[0], 4'h0, s[1:0]});
				run(8'h41, 40);
				`CHK(c, 0)
				src_model_inst.set_src(s, p[0]);
				run(8'h41, 40);
				rng(38, 46);
				src_model_inst.set_src(s, 1'b0);
			end
		end
	endtask
	task automatic t_toggle();
		wr(12'h004, 8'hc1);
		wr(12'h004, 8'he1);
		wr(12'h000, 8'h41);
		src_model_inst.roll_pulse();
		repeat (6) @(posedge pclk);
		`CHK(gate_value, 1'b1)
		src_model_inst.roll_pulse();
		repeat (6) @(posedge pclk);
		`CHK(gate_value, 1'b0)
		src_model_inst.roll_pulse();
		repeat (6) @(posedge pclk);
		wr(12'h000, 8'h40);
		repeat (4) @(posedge pclk);
		`CHK(gate_value, 1'b0)
		wr(12'h004, 8'hc1);
		repeat (4) @(posedge pclk);
		`CHK(gate_value, 1'b0)
	endtask
	task automatic t_roll();
		wr(12'h000, 8'h40);
		wr(12'h004, 8'h00);
		wr(12'h008, 8'hff);
		wr(12'h00c, 8'hff);
		wr(12'h000, 8'h41);
		repeat (4) @(posedge pclk);
		wr(12'h000, 8'h40);
		`CHK(rollover_flag, 1'b1)
		rdc();
		rng(1, 8);
		wr(12'h010, 8'h01);
		@(posedge pclk);
		`CHK(rollover_flag, 1'b0)
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Cuts a hang well past the length of a normal run
	initial begin
		#900000;
		err_count++;
		report_and_stop();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_clk();
		t_ext();
		t_gate();
		t_toggle();
		t_roll();
		report_and_stop();
	end
endmodule
